// File: dv/event_stub.sv
// stand-in for comparators and counters driving the six inputs
// assumes one request per cycle; pins idle low between pulses
`timescale 1ns/1ps
module event_stub (
	input  wire       i_clk,
	input  wire       i_srst,
	input  wire [5:0] i_fire,
	output reg  [5:0] o_pins
);
	// ==========================================================
	// one-cycle pulses on request
	always @(posedge i_clk) begin
		if (i_srst)
			o_pins <= 6'h00;
		else
			o_pins <= i_fire;
	end
endmodule

// File: dv/seq_props.sv
// assertions on the event sequencer ports
// assumes binding into event_sequencer, single clock domain
`timescale 1ns/1ps
`include "event_sequencer_consts.vh"
module seq_props (
	input logic        i_clk,
	input logic        i_srst,
	input logic        i_event_input_a,
	input logic        i_event_input_b,
	input logic        i_event_input_c,
	input logic        i_event_input_d,
	input logic        i_first_counter_zero_input,
	input logic        i_second_counter_zero_input,
	input logic        s_axi_wvalid,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [2:0]  o_first_counter_zero_input_action,
	input logic [1:0]  o_trace_action,
	input logic        o_trace_enable,
	input logic        o_breakpoint,
	input logic        o_trigger,
	input logic        o_irq
);
	// ==========================================================
	// helpers
	wire any_in = i_event_input_a | i_event_input_b | i_event_input_c | i_event_input_d
		| i_first_counter_zero_input | i_second_counter_zero_input;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	sequence trig_tail;
		o_trigger ##1 !o_trigger;
	endsequence
	sequence no_recent_write;
		!s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) && !$past(s_axi_wvalid, 3);
	endsequence
	// ==========================================================
	// properties
	a_brk_one_cycle: assert property (o_breakpoint |=> !o_breakpoint)
		else $error("breakpoint pulse too long");
	a_trig_two_cycles: assert property ($rose(o_trigger) |=> trig_tail)
		else $error("trigger pulse not two cycles");
	a_cnt_one_shot: assert property ((o_first_counter_zero_input_action != `CNT_ACT_NONE) |=> (o_first_counter_zero_input_action == `CNT_ACT_NONE))
		else $error("counter action not one cycle");
	a_trc_one_shot: assert property ((o_trace_action != `TRC_ACT_NONE) |=> (o_trace_action == `TRC_ACT_NONE))
		else $error("trace action not one cycle");
	a_trc_disable_cause: assert property ($fell(o_trace_enable) |-> (o_trace_action == `TRC_ACT_DISABLE))
		else $error("trace enable dropped without disable");
	a_detect_has_cause: assert property (o_breakpoint
		|-> ($past(any_in, 2) || $past(any_in, 3) || $past(any_in, 4) || $past(any_in, 5)))
		else $error("detection without input activity");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_irq_sticky: assert property (o_irq ##0 no_recent_write |=> o_irq)
		else $error("interrupt dropped without a write");
endmodule

// File: dv/tb.sv
// testbench for the event sequencer
// assumes the axi4-lite slave and event stub; single clock
`timescale 1ns/1ps
`include "event_sequencer_consts.vh"
module tb;
	logic        i_clk = 0, i_srst = 1, i_cycle_qual = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp, o_trace_action;
	wire [31:0]  s_axi_rdata;
	wire [2:0]   o_first_counter_zero_input_action, o_second_counter_zero_input_action;
	wire         o_trace_enable, o_breakpoint, o_trigger, o_irq;
	wire         i_event_input_a, i_event_input_b, i_event_input_c, i_event_input_d;
	wire         i_first_counter_zero_input, i_second_counter_zero_input;
	logic [5:0]  fire_q = 0;
	logic [2:0]  c1_seen = 0, c2_seen = 0;
	logic [1:0]  tr_seen = 0, r;
	int          fail_count = 0, total_checks = 0, cyc = 0, brk_n = 0, trig_n = 0, i, j;
	// ==========================================================
	// instances
	event_stub i_event_stub (.i_clk, .i_srst, .i_fire(fire_q), .o_pins({i_second_counter_zero_input,
		i_first_counter_zero_input, i_event_input_d, i_event_input_c, i_event_input_b, i_event_input_a}));
	event_sequencer i_event_sequencer (.*);
	initial forever #5 i_clk = ~i_clk;
	// ==========================================================
	// output monitors and timeout
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_first_counter_zero_input_action != 0) c1_seen <= o_first_counter_zero_input_action;
		if (o_second_counter_zero_input_action != 0) c2_seen <= o_second_counter_zero_input_action;
		if (o_trace_action != 0) tr_seen <= o_trace_action;
		if (o_breakpoint) brk_n <= brk_n + 1;
		if (o_trigger) trig_n <= trig_n + 1;
		if (cyc == 30000) begin
			fail_count++;
			end_of_test;
		end
	end
	// ==========================================================
	// tasks
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %s exp %h seen %h", n, e, s);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		logic ha, hw, hb, bv;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(negedge i_clk);
			ha = s_axi_awready & s_axi_awvalid;
			hw = s_axi_wready & s_axi_wvalid;
			hb = s_axi_bvalid & s_axi_bready;
			bv = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge i_clk);
			if (ha) s_axi_awvalid <= 0;
			if (hw) s_axi_wvalid <= 0;
			if (bv && !hb) s_axi_bready <= 1;
		end while (!hb);
		s_axi_bready <= 0;
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] rr);
		logic ha, hb, rv;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1;
		do begin
			@(negedge i_clk);
			ha = s_axi_arready & s_axi_arvalid;
			hb = s_axi_rvalid & s_axi_rready;
			rv = s_axi_rvalid;
			v = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge i_clk);
			if (ha) s_axi_arvalid <= 0;
			if (rv && !hb) s_axi_rready <= 1;
		end while (!hb);
		s_axi_rready <= 0;
	endtask
	task rchk(input string n, input [7:0] a, input [31:0] e);
		rd(a, d, r);
		chk(n, d, e);
	endtask
	task fire(input [5:0] p);
		fire_q <= p;
		@(posedge i_clk);
		fire_q <= 0;
		repeat (6) @(posedge i_clk);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge i_clk);
		i_srst <= 0;
		repeat (2) @(posedge i_clk);
		wr(`REG_CTRL, 32'h0000_0006);
		wr(`REG_ACT_CTRL, 32'h0000_00e3);
		wr(8'h04, 1);
		wr(8'h08, 4);
		wr(8'h0c, 1);
		fire(6'h01);
		fire(6'h04);
		rchk("level", `REG_STATUS, 1);
		fire(6'h02);
		rchk("level", `REG_STATUS, 2);
		fire(6'h01);
		rchk("status", `REG_STATUS, 32'h0000_0010);
		chk("first_counter_zero_input act", c1_seen, 3);
		chk("second_counter_zero_input act", c2_seen, 4);
		chk("trace act", tr_seen, 3);
		chk("brk", brk_n, 1);
		chk("trigger", trig_n, 2);
		chk("trace en", o_trace_enable, 0);
		fire(6'h01);
		chk("trace held", o_trace_enable, 0);
		wr(`REG_CTRL, 32'h0000_000e);
		rchk("ctrl", `REG_CTRL, 32'h0000_000e);
		rchk("int stat", `REG_INT_STAT, 1);
		wr(`REG_INT_MASK, 0);
		repeat (3) @(posedge i_clk);
		chk("irq masked", o_irq, 0);
		wr(`REG_INT_MASK, 3);
		repeat (3) @(posedge i_clk);
		chk("irq mask", o_irq, 1);
		wr(`REG_INT_STAT, 3);
		repeat (3) @(posedge i_clk);
		chk("irq clear", o_irq, 0);
		$display("test actions done");
		wr(`REG_CTRL, 1);
		rchk("cleared sel", 8'h04, 0);
		rchk("cleared lvl", `REG_STATUS, 0);
		wr(8'h04, 1);
		wr(8'h08, 1);
		wr(8'h0c, 6);
		fire(6'h01);
		fire(6'h01);
		rchk("level", `REG_STATUS, 2);
		fire(6'h01);
		rchk("after reset", `REG_STATUS, 0);
		rchk("int reset", `REG_INT_STAT, 2);
		fire(6'h01);
		fire(6'h01);
		fire(6'h03);
		rchk("adv wins", `REG_STATUS, 32'h0000_0010);
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			j = (i + 1) % 6;
			wr(`REG_CTRL, 1);
			wr(8'h04, 1 << (2 * i));
			wr(8'h08, (1 << (2 * i)) | (2 << (2 * j)));
			fire(6'h01 << j);
			fire(6'h01 << i);
			rchk("in level", `REG_STATUS, 1);
			fire(6'h01 << j);
			rchk("in reset", `REG_STATUS, 0);
			fire(6'h01 << i);
			fire(6'h01 << i);
			rchk("in detect", `REG_STATUS, 32'h0000_0010);
		end
		chk("brk off", brk_n, 1);
		chk("trigger off", trig_n, 2);
		i_cycle_qual <= 0;
		fire(6'h20);
		rchk("unqualified", `REG_STATUS, 32'h0000_0010);
		i_cycle_qual <= 1;
		fire(6'h20);
		rchk("qualified", `REG_STATUS, 32'h0000_0011);
		rd(8'h40, d, r);
		chk("unmapped", r, `AXI_RESP_SLVERR);
		wr(8'h40, 0);
		chk("unmapped wr", r, `AXI_RESP_SLVERR);
		$display("test inputs done");
		end_of_test;
	end
endmodule
bind event_sequencer seq_props i_seq_props (.*);

// File: hdl/event_sequencer.v
// event sequencer: up to eight levels over six inputs, with actions on detection
// assumes axi4-lite master on i_clk; event inputs and qualifier asynchronous
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "event_sequencer_consts.vh"

module event_sequencer #(
	parameter N_IN  = `SEQ_NUM_INPUTS,
	parameter N_LVL = `SEQ_NUM_LEVELS
) (
	input  wire        i_clk,
	input  wire        i_srst,
	input  wire        i_event_input_a,
	input  wire        i_event_input_b,
	input  wire        i_event_input_c,
	input  wire        i_event_input_d,
	input  wire        i_first_counter_zero_input,
	input  wire        i_second_counter_zero_input,
	input  wire        i_cycle_qual,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [2:0]  o_first_counter_zero_input_action,
	output reg  [2:0]  o_second_counter_zero_input_action,
	output reg  [1:0]  o_trace_action,
	output reg         o_trace_enable,
	output reg         o_breakpoint,
	output reg         o_trigger,
	output reg         o_irq
);
	// ==========================================================================
	// constants
	localparam integer TRIG_CYC_RAW = `TRIG_PULSE_NS / `CLK_PERIOD_NS;
	localparam integer TRIG_CYC     = (TRIG_CYC_RAW < 1) ? 1 : TRIG_CYC_RAW;
	localparam [3:0]   TRIG_LOAD    = TRIG_CYC[3:0];

	// ==========================================================================
	// input synchronisation
	wire [N_IN:0] raw_in = {i_cycle_qual, i_second_counter_zero_input, i_first_counter_zero_input,
		i_event_input_d, i_event_input_c, i_event_input_b, i_event_input_a};
	wire [N_IN:0] sync_in;

	seq_sync2 #(.W(N_IN+1)) u_sync (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.i_d    (raw_in),
		.o_q    (sync_in)
	);

	wire [N_IN-1:0] hit = sync_in[N_IN] ? sync_in[N_IN-1:0] : {N_IN{1'b0}};

	// ==========================================================================
	// registers
	reg [2*N_IN-1:0] sel_q [0:N_LVL-1];
	reg [`SEQ_LVL_W-1:0] level_q;
	reg              trig_en_q;
	reg              brk_en_q;
	reg [7:0]        act_q;
	reg [`INT_W-1:0] int_stat_q;
	reg [`INT_W-1:0] int_mask_q;
	reg              trc_disabled_q;
	reg [31:0]       det_count_q;
	reg [3:0]        trig_cnt_q;

	// ==========================================================================
	// per-level match
	wire [N_LVL-1:0] lvl_adv;
	wire [N_LVL-1:0] lvl_rst;
	wire [N_LVL-1:0] lvl_def;
	genvar gl;
	generate
		for (gl = 0; gl < N_LVL; gl = gl + 1) begin : g_lvl
			seq_level_match #(.N_IN(N_IN)) u_match (
				.i_sel     (sel_q[gl]),
				.i_hit     (hit),
				.o_adv     (lvl_adv[gl]),
				.o_rst     (lvl_rst[gl]),
				.o_defined (lvl_def[gl])
			);
		end
	endgenerate

	// highest defined level sets the sequence length
	reg [`SEQ_LVL_W-1:0] last_lvl;
	integer k;
	always @* begin
		last_lvl = {`SEQ_LVL_W{1'b0}};
		for (k = 0; k < N_LVL; k = k + 1) begin
			if (lvl_def[k]) begin
				last_lvl = k[`SEQ_LVL_W-1:0];
			end
		end
	end

	wire any_def   = |lvl_def;
	wire cur_adv   = lvl_adv[level_q];
	wire cur_rst   = lvl_rst[level_q];
	wire at_last   = (level_q == last_lvl);
	wire detect    = any_def & cur_adv & at_last;
	wire do_reset  = any_def & cur_rst & ~cur_adv;

	// ==========================================================================
	// axi write path
	reg        aw_have_q;
	reg        w_have_q;
	reg [7:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;

	wire        wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire [31:0] wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [7:0]  wa_lvl  = aw_addr_q - `REG_LEVEL_BASE;
	wire        wr_lvl  = (aw_addr_q >= `REG_LEVEL_BASE) && (aw_addr_q < `REG_STATUS) && (aw_addr_q[1:0] == 2'h0);
	wire        wr_ctrl = wr_fire && (aw_addr_q == `REG_CTRL);
	wire        clr_cfg = wr_ctrl && w_strb_q[0] && w_data_q[`CTRL_CLEAR_BIT];
	wire        wr_map  = (aw_addr_q == `REG_CTRL) || wr_lvl || (aw_addr_q == `REG_STATUS)
		|| (aw_addr_q == `REG_INT_STAT) || (aw_addr_q == `REG_INT_MASK) || (aw_addr_q == `REG_ACT_CTRL);
	wire        trc_reen = wr_ctrl && w_strb_q[0] && w_data_q[`CTRL_TRC_EN_BIT];

	integer i;
	always @(posedge i_clk) begin
		if (i_srst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AXI_RESP_OKAY;
			trig_en_q     <= 1'b0;
			brk_en_q      <= 1'b0;
			act_q         <= 8'h00;
			int_mask_q    <= {`INT_W{1'b0}};
			for (i = 0; i < N_LVL; i = i + 1) begin
				sel_q[i] <= {2*N_IN{1'b0}};
			end
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready;
			s_axi_wready  <= ~w_have_q & ~s_axi_wready;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				if (aw_addr_q == `REG_CTRL) begin
					if (w_strb_q[0]) begin
						trig_en_q <= w_data_q[`CTRL_TRIG_BIT];
						brk_en_q  <= w_data_q[`CTRL_BRK_BIT];
					end
				end
				if (aw_addr_q == `REG_INT_MASK && w_strb_q[0]) begin
					int_mask_q <= w_data_q[`INT_W-1:0];
				end
				if (aw_addr_q == `REG_ACT_CTRL && w_strb_q[0]) begin
					act_q <= w_data_q[7:0];
				end
				if (wr_lvl) begin
					sel_q[wa_lvl[4:2]] <= (sel_q[wa_lvl[4:2]] & ~wmask[2*N_IN-1:0])
						| (w_data_q[2*N_IN-1:0] & wmask[2*N_IN-1:0]);
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (clr_cfg) begin
				for (i = 0; i < N_LVL; i = i + 1) begin
					sel_q[i] <= {2*N_IN{1'b0}};
				end
			end
		end
	end

	// ==========================================================================
	// axi read path
	always @(posedge i_clk) begin
		if (i_srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AXI_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `AXI_RESP_OKAY;
				s_axi_rdata   <= 32'h0000_0000;
				if (s_axi_araddr[7:0] == `REG_CTRL) begin
					s_axi_rdata <= {28'h000_0000, ~trc_disabled_q, brk_en_q, trig_en_q, 1'b0};
				end else if (s_axi_araddr[7:0] >= `REG_LEVEL_BASE && s_axi_araddr[7:0] < `REG_STATUS
					&& s_axi_araddr[1:0] == 2'h0) begin
					s_axi_rdata <= {{(32-2*N_IN){1'b0}}, sel_q[s_axi_araddr[4:2] - 3'h1]};
				end else if (s_axi_araddr[7:0] == `REG_STATUS) begin
					s_axi_rdata <= {det_count_q[27:0], 1'b0, level_q};
				end else if (s_axi_araddr[7:0] == `REG_INT_STAT) begin
					s_axi_rdata <= {30'h0000_0000, int_stat_q};
				end else if (s_axi_araddr[7:0] == `REG_INT_MASK) begin
					s_axi_rdata <= {30'h0000_0000, int_mask_q};
				end else if (s_axi_araddr[7:0] == `REG_ACT_CTRL) begin
					s_axi_rdata <= {24'h00_0000, act_q};
				end else begin
					s_axi_rresp <= `AXI_RESP_SLVERR;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// sequencer level state
	always @(posedge i_clk) begin
		if (i_srst || clr_cfg) begin
			level_q     <= {`SEQ_LVL_W{1'b0}};
			det_count_q <= 32'h0000_0000;
		end else if (detect) begin
			level_q     <= {`SEQ_LVL_W{1'b0}};
			det_count_q <= det_count_q + 32'h0000_0001;
		end else if (do_reset) begin
			level_q <= {`SEQ_LVL_W{1'b0}};
		end else if (any_def && cur_adv) begin
			level_q <= level_q + 3'h1;
		end
		// no hit on current level: hold
	end

	// ==========================================================================
	// actions and interrupts
	wire [`INT_W-1:0] int_set = {do_reset, detect};
	wire [`INT_W-1:0] int_clr = (wr_fire && aw_addr_q == `REG_INT_STAT && w_strb_q[0])
		? w_data_q[`INT_W-1:0] : {`INT_W{1'b0}};
	wire [1:0] trc_act = act_q[`ACT_TRC_LSB +: `ACT_TRC_W];

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_first_counter_zero_input_action  <= `CNT_ACT_NONE;
			o_second_counter_zero_input_action  <= `CNT_ACT_NONE;
			o_trace_action <= `TRC_ACT_NONE;
			o_trace_enable <= 1'b1;
			trc_disabled_q <= 1'b0;
			o_breakpoint   <= 1'b0;
			o_trigger      <= 1'b0;
			trig_cnt_q     <= 4'h0;
			int_stat_q     <= {`INT_W{1'b0}};
			o_irq          <= 1'b0;
		end else begin
			o_first_counter_zero_input_action  <= detect ? act_q[`ACT_FIRST_COUNTER_ZERO_INPUT_LSB +: `ACT_CNT_W] : `CNT_ACT_NONE;
			o_second_counter_zero_input_action  <= detect ? act_q[`ACT_SECOND_COUNTER_ZERO_INPUT_LSB +: `ACT_CNT_W] : `CNT_ACT_NONE;
			o_trace_action <= detect ? trc_act : `TRC_ACT_NONE;
			if (detect && trc_act == `TRC_ACT_DISABLE) begin
				trc_disabled_q <= 1'b1;
				o_trace_enable <= 1'b0;
			end else if (trc_reen) begin
				trc_disabled_q <= 1'b0;
				o_trace_enable <= 1'b1;
			end
			o_breakpoint <= detect & brk_en_q;
			if (detect && trig_en_q) begin
				trig_cnt_q <= TRIG_LOAD - 4'h1;
				o_trigger  <= 1'b1;
			end else if (trig_cnt_q != 4'h0) begin
				trig_cnt_q <= trig_cnt_q - 4'h1;
			end else begin
				o_trigger <= 1'b0;
			end
			int_stat_q <= (int_stat_q & ~int_clr) | int_set;
			o_irq      <= |(((int_stat_q & ~int_clr) | int_set) & int_mask_q);
		end
	end
endmodule

// File: hdl/event_sequencer_consts.vh
// constants for the event sequencer: register map, field positions, timing
// assumes 32-bit axi4-lite data and byte addressing
`ifndef EVENT_SEQUENCER_CONSTS_VH
`define EVENT_SEQUENCER_CONSTS_VH

// ==========================================================================
// sizes
`define SEQ_NUM_INPUTS   6
`define SEQ_NUM_LEVELS   8
`define SEQ_LVL_W        3

// ==========================================================================
// selection encoding per input and level
`define SEL_NONE         2'h0
`define SEL_ADV          2'h1
`define SEL_RST          2'h2

// ==========================================================================
// register byte offsets
`define REG_CTRL         8'h00
`define REG_LEVEL_BASE   8'h04
`define REG_STATUS       8'h24
`define REG_INT_STAT     8'h28
`define REG_INT_MASK     8'h2C
`define REG_ACT_CTRL     8'h30

// ==========================================================================
// ctrl fields
`define CTRL_CLEAR_BIT   0
`define CTRL_TRIG_BIT    1
`define CTRL_BRK_BIT     2
`define CTRL_TRC_EN_BIT  3

// action control fields
`define ACT_FIRST_COUNTER_ZERO_INPUT_LSB     0
`define ACT_SECOND_COUNTER_ZERO_INPUT_LSB     3
`define ACT_TRC_LSB      6
`define ACT_CNT_W        3
`define ACT_TRC_W        2

// counter actions
`define CNT_ACT_NONE     3'h0
`define CNT_ACT_START    3'h1
`define CNT_ACT_STOP     3'h2
`define CNT_ACT_DEC      3'h3
`define CNT_ACT_RELOAD   3'h4

// trace actions
`define TRC_ACT_NONE     2'h0
`define TRC_ACT_START    2'h1
`define TRC_ACT_STOP     2'h2
`define TRC_ACT_DISABLE  2'h3

// interrupt bits
`define INT_DETECT_BIT   0
`define INT_RESET_BIT    1
`define INT_W            2

// axi responses
`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2

// trigger pulse width
`define TRIG_PULSE_NS    20
`define CLK_PERIOD_NS    10

`endif

// File: hdl/seq_level_match.v
// one level of selections: advance and reset hit detection
// assumes inputs already synchronised and qualified
`timescale 1ns/1ps
`include "event_sequencer_consts.vh"

module seq_level_match #(
	parameter N_IN = `SEQ_NUM_INPUTS
) (
	input  wire [2*N_IN-1:0] i_sel,
	input  wire [N_IN-1:0]   i_hit,
	output wire              o_adv,
	output wire              o_rst,
	output wire              o_defined
);
	// ==========================================================================
	// per-input decode
	wire [N_IN-1:0] adv_v;
	wire [N_IN-1:0] rst_v;
	genvar g;
	generate
		for (g = 0; g < N_IN; g = g + 1) begin : g_in
			assign adv_v[g] = (i_sel[2*g+1:2*g] == `SEL_ADV);
			assign rst_v[g] = (i_sel[2*g+1:2*g] == `SEL_RST);
		end
	endgenerate

	assign o_adv     = |(adv_v & i_hit);
	assign o_rst     = |(rst_v & i_hit);
	assign o_defined = |adv_v;
endmodule

// File: hdl/seq_sync2.v
// two-flop synchroniser for a bus of levels
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps

module seq_sync2 #(
	parameter W = 1
) (
	input  wire         i_clk,
	input  wire         i_srst,
	input  wire [W-1:0] i_d,
	output reg  [W-1:0] o_q
);
	// ==========================================================================
	// two stages
	reg [W-1:0] meta_q;

	always @(posedge i_clk) begin
		if (i_srst) begin
			meta_q <= {W{1'b0}};
			o_q    <= {W{1'b0}};
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule
